// ---- inc/timer_pkg.sv ----
// How it works
// (RULE1) A 32-bit main counter advances through a programmable 32-bit prescaler.
// (RULE2) Counting uses the peripheral clock or an external clock, chosen by configuration.
// (RULE3) One capture input may be chosen as the counting clock source.
// (RULE4) A configured capture input edge copies the counter into its capture register.
// (RULE5) Among several enabled pins for one capture channel, the lowest-numbered pin is used.
// (RULE6) Four 32-bit match registers are compared against the counter.
// (RULE7) A match may let counting continue, optionally raising an interrupt.
// (RULE8) A match may halt the counter, optionally raising an interrupt.
// (RULE9) A match may reset the counter, optionally raising an interrupt.
// (RULE10) A match drives its external output low, high, toggled or unchanged.
// (RULE11) One match output function may drive several selected pins at once.
// (RULE12) Every instance behaves identically; only the base address differs.
// (RULE13) The counter advances once every prescale limit plus one counting clocks.
// (RULE14) Prescale count climbs to the limit, then clears as the counter increments.
// (RULE15) An eight-bit flag register shows pending interrupts and is written to clear; the code also clears the flags when the register is read.
// (RULE16) The control register can disable the counter or hold it in reset.
// (RULE17) Capture inputs are synchronised to the clock before edges are detected.
// (RULE18) A stop-on-match clears the enable, freezing counter and prescaler until re-enabled.
`default_nettype none
package timer_pkg;
   localparam int ADDR_W = 8;
   localparam int CHANNELS = 4;
   // Register byte offsets.
   localparam logic [7:0] OFF_IR     = 8'h00;
   localparam logic [7:0] OFF_TCR    = 8'h04;
   localparam logic [7:0] OFF_TC     = 8'h08;
   localparam logic [7:0] OFF_PR     = 8'h0C;
   localparam logic [7:0] OFF_PC     = 8'h10;
   localparam logic [7:0] OFF_MCR    = 8'h14;
   localparam logic [7:0] OFF_CCR    = 8'h18;
   localparam logic [7:0] OFF_EMR    = 8'h1C;
   localparam logic [7:0] OFF_MR0    = 8'h20;
   localparam logic [7:0] OFF_CR0    = 8'h30;
   localparam logic [7:0] OFF_CTCR   = 8'h70;
   localparam logic [7:0] OFF_CAPSEL = 8'h74;
   localparam logic [7:0] OFF_MATSEL = 8'h78;
   localparam logic [7:0] OFF_MASK   = 8'h7C;
   // Field positions.
   localparam int TCR_EN    = 0;
   localparam int TCR_RST   = 1;
   localparam int MCR_IRQ   = 0;
   localparam int MCR_RST   = 1;
   localparam int MCR_STOP  = 2;
   localparam int CCR_RISE  = 0;
   localparam int CCR_FALL  = 1;
   localparam int CCR_IRQ   = 2;
   localparam int FIELD_W   = 3;
   localparam int EMR_CTRL  = 4;
   localparam int IR_CAP    = 4;
   localparam int CTCR_SRC  = 2;
   // Encodings.
   localparam logic [1:0] MODE_TIMER = 2'h0;
   localparam logic [1:0] MODE_RISE  = 2'h1;
   localparam logic [1:0] MODE_FALL  = 2'h2;
   localparam logic [1:0] MODE_BOTH  = 2'h3;
   localparam logic [1:0] EM_NONE    = 2'h0;
   localparam logic [1:0] EM_LOW     = 2'h1;
   localparam logic [1:0] EM_HIGH    = 2'h2;
   localparam logic [1:0] EM_TOGGLE  = 2'h3;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Value of every register after reset.
   localparam logic [31:0] RST_WORD  = 32'h0000_0000;

   function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return res;
   endfunction
endpackage
`default_nettype wire

// ---- verilog/capture_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module capture_sync #(
   parameter int PINS = 3
) (
   // Clock and reset.
   input  wire logic            aclk,
   input  wire logic            aresetn,
   // Pins and selection.
   input  wire logic [PINS-1:0] pins,
   input  wire logic [PINS-1:0] pin_enable,
   // Edge strobes.
   output logic                 rise,
   output logic                 fall
);
   logic [PINS-1:0] meta_q;
   logic [PINS-1:0] sync_q;
   logic            level_d;
   logic            level_q;

   // The first stage feeds only the second; all selection works on clean levels.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q  <= '0;
         sync_q  <= '0;
         level_q <= 1'b0;
      end else begin
         meta_q  <= pins;    // RULE17
         sync_q  <= meta_q;  // RULE17
         level_q <= level_d;
      end
   end

   // Scanning downward lets the lowest enabled pin overwrite any higher one.
   always_comb begin
      level_d = 1'b0;
      for (int k = PINS - 1; k >= 0; k--) begin
         if (pin_enable[k]) begin
            level_d = sync_q[k];  // RULE5
         end
      end
   end

   assign rise = level_d & ~level_q;
   assign fall = ~level_d & level_q;
endmodule
`default_nettype wire

// ---- verilog/prescaled_timer.sv ----
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module prescaled_timer #(
   parameter int CAP_PINS = 3,
   parameter int MAT_PINS = 2
) (
   // Clock and reset.
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   // AXI4-Lite write address and data.
   input  wire logic                          awvalid,
   output logic                               awready,
   input  wire logic [timer_pkg::ADDR_W-1:0]  awaddr,
   input  wire logic [2:0]                    awprot,
   input  wire logic                          wvalid,
   output logic                               wready,
   input  wire logic [31:0]                   wdata,
   input  wire logic [3:0]                    wstrb,
   // AXI4-Lite write response.
   output logic                               bvalid,
   input  wire logic                          bready,
   output logic [1:0]                         bresp,
   // AXI4-Lite read.
   input  wire logic                          arvalid,
   output logic                               arready,
   input  wire logic [timer_pkg::ADDR_W-1:0]  araddr,
   input  wire logic [2:0]                    arprot,
   output logic                               rvalid,
   input  wire logic                          rready,
   output logic [31:0]                        rdata,
   output logic [1:0]                         rresp,
   // Capture pins, CAP_PINS per channel.
   input  wire logic [4*CAP_PINS-1:0]         capture_pins,
   // Match outputs and their pins, MAT_PINS per channel.
   output logic [3:0]                         match_outputs,
   output logic [4*MAT_PINS-1:0]              match_pins,
   // Interrupt.
   output logic                               irq
);
   import timer_pkg::*;

   if (CAP_PINS < 1 || CAP_PINS > 8 || MAT_PINS < 1 || MAT_PINS > 8) begin : g_bad_params
      $error("prescaled_timer: pin counts must lie between 1 and 8");
   end

   logic [7:0]            ir_q;
   logic [7:0]            mask_q;
   logic [1:0]            tcr_q;
   logic [31:0]           tc_q;
   logic [31:0]           pr_q;
   logic [31:0]           pc_q;
   logic [11:0]           mcr_q;
   logic [11:0]           ccr_q;
   logic [11:0]           emr_q;
   logic [3:0]            ctcr_q;
   logic [31:0]           mr_q [4];
   logic [31:0]           cr_q [4];
   logic [4*CAP_PINS-1:0] capsel_q;
   logic [4*MAT_PINS-1:0] matsel_q;
   logic [4*MAT_PINS-1:0] match_pins_q;
   logic                  irq_q;

   // Bus slave state.
   logic                  aw_full_q;
   logic [ADDR_W-1:0]     aw_addr_q;
   logic                  w_full_q;
   logic [31:0]           w_data_q;
   logic [3:0]            w_strb_q;
   logic                  bvalid_q;
   logic [1:0]            bresp_q;
   logic                  rvalid_q;
   logic [31:0]           rdata_q;
   logic [1:0]            rresp_q;

   assign awready = ~aw_full_q;
   assign wready  = ~w_full_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign arready = ~rvalid_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;

   // Address and data are parked separately, so either may arrive first.
   wire wr_go = aw_full_q & w_full_q & ~bvalid_q;
   wire rd_go = arvalid & ~rvalid_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         aw_addr_q <= '0;
      end else if (awvalid && !aw_full_q) begin
         aw_full_q <= 1'b1;
         aw_addr_q <= awaddr;
      end else if (wr_go) begin
         aw_full_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_q <= 1'b0;
         w_data_q <= RST_WORD;
         w_strb_q <= 4'h0;
      end else if (wvalid && !w_full_q) begin
         w_full_q <= 1'b1;
         w_data_q <= wdata;
         w_strb_q <= wstrb;
      end else if (wr_go) begin
         w_full_q <= 1'b0;
      end
   end

   // Write decode.
   wire [7:0] wa      = {aw_addr_q[ADDR_W-1:2], 2'h0};  // RULE12
   wire       h_ir    = (wa == OFF_IR);
   wire       h_tcr   = (wa == OFF_TCR);
   wire       h_tc    = (wa == OFF_TC);
   wire       h_pr    = (wa == OFF_PR);
   wire       h_pc    = (wa == OFF_PC);
   wire       h_mcr   = (wa == OFF_MCR);
   wire       h_ccr   = (wa == OFF_CCR);
   wire       h_emr   = (wa == OFF_EMR);
   wire       h_mr    = (wa[7:4] == OFF_MR0[7:4]);
   wire       h_ctcr  = (wa == OFF_CTCR);
   wire       h_capsl = (wa == OFF_CAPSEL);
   wire       h_matsl = (wa == OFF_MATSEL);
   wire       h_mask  = (wa == OFF_MASK);
   wire       w_map   = h_ir | h_tcr | h_tc | h_pr | h_pc | h_mcr | h_ccr | h_emr | h_mr
                        | h_ctcr | h_capsl | h_matsl | h_mask;

   function automatic logic [31:0] wmerge(input logic [31:0] old_v);
      return apply_strb(old_v, w_data_q, w_strb_q);
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q  <= w_map ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Read decode and data selection.
   wire [7:0] ra      = {araddr[ADDR_W-1:2], 2'h0};
   wire       r_ir    = (ra == OFF_IR);
   wire       r_mr    = (ra[7:4] == OFF_MR0[7:4]);
   wire       r_cr    = (ra[7:4] == OFF_CR0[7:4]);
   wire       r_map   = r_ir | r_mr | r_cr | (ra == OFF_TCR) | (ra == OFF_TC) | (ra == OFF_PR)
                        | (ra == OFF_PC) | (ra == OFF_MCR) | (ra == OFF_CCR) | (ra == OFF_EMR)
                        | (ra == OFF_CTCR) | (ra == OFF_CAPSEL) | (ra == OFF_MATSEL)
                        | (ra == OFF_MASK);
   wire [31:0] rd_mux =
        ({32{r_ir}}               & {24'h00_0000, ir_q})
      | ({32{ra == OFF_TCR}}      & {30'h0000_0000, tcr_q})
      | ({32{ra == OFF_TC}}       & tc_q)
      | ({32{ra == OFF_PR}}       & pr_q)
      | ({32{ra == OFF_PC}}       & pc_q)
      | ({32{ra == OFF_MCR}}      & {20'h0_0000, mcr_q})
      | ({32{ra == OFF_CCR}}      & {20'h0_0000, ccr_q})
      | ({32{ra == OFF_EMR}}      & {20'h0_0000, emr_q})
      | ({32{r_mr}}               & mr_q[ra[3:2]])
      | ({32{r_cr}}               & cr_q[ra[3:2]])
      | ({32{ra == OFF_CTCR}}     & {28'h000_0000, ctcr_q})
      | ({32{ra == OFF_CAPSEL}}   & 32'(capsel_q))
      | ({32{ra == OFF_MATSEL}}   & 32'(matsel_q))
      | ({32{ra == OFF_MASK}}     & {24'h00_0000, mask_q});

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= RST_WORD;
         rresp_q  <= RESP_OKAY;
      end else if (rd_go) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_mux;
         rresp_q  <= r_map ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // Counting engine.
   logic [3:0] rise;
   logic [3:0] fall;
   logic [3:0] hit;
   logic [3:0] rst_hit;
   logic [3:0] stop_hit;
   logic [3:0] cap_go;
   logic [3:0] emr_nxt;
   logic [7:0] ir_set;

   wire [1:0]  mode     = ctcr_q[1:0];
   wire [1:0]  src      = ctcr_q[CTCR_SRC +: 2];
   wire        run      = tcr_q[TCR_EN] & ~tcr_q[TCR_RST];                     // RULE16
   wire        ext_edge = ((mode == MODE_RISE) & rise[src])                    // RULE3
                        | ((mode == MODE_FALL) & fall[src])
                        | ((mode == MODE_BOTH) & (rise[src] | fall[src]));
   wire        tick     = (mode == MODE_TIMER) | ext_edge;                    // RULE2
   wire        adv      = run & tick & (pc_q == pr_q);                        // RULE13
   wire        any_rst  = |rst_hit;
   wire [31:0] tc_nxt   = any_rst ? RST_WORD : tc_q + 32'h0000_0001;          // RULE1
   wire [11:0] emr_wr   = 12'(wmerge({20'h0_0000, emr_q}));
   wire [31:0] capsel_wr = wmerge(32'(capsel_q));
   wire [31:0] matsel_wr = wmerge(32'(matsel_q));
   wire [3:0]  emr_base = (wr_go & h_emr) ? emr_wr[3:0] : emr_q[3:0];

   for (genvar i = 0; i < 4; i++) begin : g_ch
      wire [1:0] ctrl = emr_q[EMR_CTRL + 2*i +: 2];

      capture_sync #(.PINS(CAP_PINS)) u_cap (
         .aclk       (aclk),
         .aresetn    (aresetn),
         .pins       (capture_pins[i*CAP_PINS +: CAP_PINS]),
         .pin_enable (capsel_q[i*CAP_PINS +: CAP_PINS]),
         .rise       (rise[i]),
         .fall       (fall[i])
      );

      assign hit[i]      = adv & (tc_nxt == mr_q[i]);                                // RULE6
      assign rst_hit[i]  = adv & mcr_q[FIELD_W*i + MCR_RST] & (tc_q == mr_q[i]);     // RULE9
      assign stop_hit[i] = hit[i] & mcr_q[FIELD_W*i + MCR_STOP];                     // RULE8
      assign ir_set[i]   = hit[i] & mcr_q[FIELD_W*i + MCR_IRQ];                      // RULE7
      assign cap_go[i]   = (rise[i] & ccr_q[FIELD_W*i + CCR_RISE])
                         | (fall[i] & ccr_q[FIELD_W*i + CCR_FALL]);
      assign ir_set[IR_CAP+i] = cap_go[i] & ccr_q[FIELD_W*i + CCR_IRQ];
      assign emr_nxt[i]  = !hit[i]            ? emr_base[i] :                        // RULE10
                           (ctrl == EM_LOW)    ? 1'b0 :
                           (ctrl == EM_HIGH)   ? 1'b1 :
                           (ctrl == EM_TOGGLE) ? ~emr_q[i] : emr_base[i];

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            cr_q[i] <= RST_WORD;
            mr_q[i] <= RST_WORD;
         end else begin
            if (cap_go[i]) begin
               cr_q[i] <= tc_q;  // RULE4
            end
            if (wr_go && h_mr && wa[3:2] == 2'(i)) begin
               mr_q[i] <= wmerge(mr_q[i]);
            end
         end
      end

      // Pins of one channel all repeat its match state where selected.
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            match_pins_q[i*MAT_PINS +: MAT_PINS] <= '0;
         end else begin
            match_pins_q[i*MAT_PINS +: MAT_PINS] <=
               {MAT_PINS{emr_q[i]}} & matsel_q[i*MAT_PINS +: MAT_PINS];  // RULE11
         end
      end
   end

   assign match_outputs = emr_q[3:0];
   assign match_pins    = match_pins_q;
   assign irq           = irq_q;

   // Counter and prescaler; the reset bit dominates a software write.
   always_ff @(posedge aclk) begin
      if (!aresetn || tcr_q[TCR_RST]) begin
         tc_q <= RST_WORD;  // RULE16
         pc_q <= RST_WORD;
      end else begin
         if (wr_go && h_tc) begin
            tc_q <= wmerge(tc_q);
         end else if (adv) begin
            tc_q <= tc_nxt;  // RULE13
         end
         if (wr_go && h_pc) begin
            pc_q <= wmerge(pc_q);
         end else if (run && tick) begin
            pc_q <= adv ? RST_WORD : pc_q + 32'h0000_0001;  // RULE14
         end
      end
   end

   // A stop on match beats a same-cycle software enable.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tcr_q <= RST_WORD[1:0];
      end else begin
         if (wr_go && h_tcr) begin
            tcr_q <= 2'(wmerge({30'h0000_0000, tcr_q}));
         end
         if (|stop_hit) begin
            tcr_q[TCR_EN] <= 1'b0;  // RULE18
         end
      end
   end

   // Flags: new events win over a read clear or a write-one clear.
   wire [7:0] ir_clr = ({8{rd_go & r_ir}})
                     | ({8{wr_go & h_ir & w_strb_q[0]}} & w_data_q[7:0]);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ir_q  <= RST_WORD[7:0];
         irq_q <= 1'b0;
      end else begin
         ir_q  <= (ir_q & ~ir_clr) | ir_set;  // RULE15
         irq_q <= |(ir_q & mask_q);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pr_q     <= RST_WORD;
         mcr_q    <= RST_WORD[11:0];
         ccr_q    <= RST_WORD[11:0];
         emr_q    <= RST_WORD[11:0];
         ctcr_q   <= RST_WORD[3:0];
         capsel_q <= '0;
         matsel_q <= '0;
         mask_q   <= RST_WORD[7:0];
      end else begin
         if (wr_go && h_pr)    pr_q     <= wmerge(pr_q);
         if (wr_go && h_mcr)   mcr_q    <= 12'(wmerge({20'h0_0000, mcr_q}));
         if (wr_go && h_ccr)   ccr_q    <= 12'(wmerge({20'h0_0000, ccr_q}));
         if (wr_go && h_ctcr)  ctcr_q   <= 4'(wmerge({28'h000_0000, ctcr_q}));
         if (wr_go && h_capsl) capsel_q <= capsel_wr[4*CAP_PINS-1:0];
         if (wr_go && h_matsl) matsel_q <= matsel_wr[4*MAT_PINS-1:0];
         if (wr_go && h_mask)  mask_q   <= 8'(wmerge({24'h00_0000, mask_q}));
         emr_q <= {(wr_go && h_emr) ? emr_wr[11:4] : emr_q[11:4], emr_nxt};
      end
   end

   // Checks.
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   wire wr_cnt = wr_go & (h_tc | h_pc | h_tcr);

   property p_prescale_wrap;
      adv && !wr_cnt |=> pc_q == 32'h0000_0000;
   endproperty
   a_prescale_wrap: assert property (p_prescale_wrap)  // RULE14
      else $error("prescale count did not clear on wrap");

   property p_tc_step;
      adv && !any_rst && !wr_cnt |=> tc_q == $past(tc_q) + 32'h0000_0001;
   endproperty
   a_tc_step: assert property (p_tc_step)  // RULE13
      else $error("counter did not step by one on advance");

   property p_tc_idle;
      !run && !wr_cnt |=> $stable(tc_q) || tc_q == 32'h0000_0000;
   endproperty
   a_tc_idle: assert property (p_tc_idle)  // RULE16
      else $error("counter moved while disabled");

   property p_hold_reset;
      tcr_q[TCR_RST] |=> tc_q == 32'h0000_0000 && pc_q == 32'h0000_0000;
   endproperty
   a_hold_reset: assert property (p_hold_reset)  // RULE16
      else $error("counter not held at zero in reset");

   property p_capture;
      cap_go[1] |=> cr_q[1] == $past(tc_q);
   endproperty
   a_capture: assert property (p_capture)  // RULE4
      else $error("capture register missed the counter value");

   property p_match_reset;
      any_rst && !wr_cnt |=> tc_q == 32'h0000_0000;
   endproperty
   a_match_reset: assert property (p_match_reset)  // RULE9
      else $error("reset on match did not clear counter");

   property p_stop;
      |stop_hit |=> !tcr_q[TCR_EN] ##1 (tcr_q[TCR_EN] || $stable(tc_q));
   endproperty
   a_stop: assert property (p_stop)  // RULE18
      else $error("stop on match did not freeze counter");

   property p_match_flag;
      hit[0] && mcr_q[MCR_IRQ] |=> ir_q[0] ##1 irq_q == mask_q[0] || $past(|(ir_q & mask_q));
   endproperty
   a_match_flag: assert property (p_match_flag)  // RULE7
      else $error("match interrupt flag not raised");

   property p_toggle;
      hit[0] && emr_q[EMR_CTRL +: 2] == EM_TOGGLE |=> match_outputs[0] != $past(emr_q[0]);
   endproperty
   a_toggle: assert property (p_toggle)  // RULE10
      else $error("match output failed to toggle");

   c_stop:    cover property (|stop_hit);
   c_capture: cover property (cap_go[1] && ccr_q[FIELD_W + CCR_IRQ]);
   c_reset:   cover property (any_rst ##1 adv);
   c_ext:     cover property (adv && mode != MODE_TIMER);
endmodule
`default_nettype wire

// ---- bench/pin_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module pin_model #(
   parameter int PINS = 12
) (
   // Clock.
   input  wire logic            aclk,
   // Requested levels and the pins that carry them.
   input  wire logic [PINS-1:0] level_req,
   output logic [PINS-1:0]      capture_pins
);
   // Pins move only just after an edge and hold whole cycles, so every level is seen.
   initial capture_pins = '0;
   always @(posedge aclk) begin
      capture_pins <= level_req;
   end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import timer_pkg::*;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, irq;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rnd;
   logic [3:0]  wstrb, match_outputs;
   logic [1:0]  bresp, rresp;
   logic [11:0] capture_pins, level_req;
   logic [7:0]  match_pins;
   logic [33:0] qr[$];
   logic [1:0]  qb[$];
   int          n_errors, total_checks, seed, n;

   prescaled_timer #(.CAP_PINS(3), .MAT_PINS(2)) u_prescaled_timer (
      .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp), .capture_pins(capture_pins), .match_outputs(match_outputs),
      .match_pins(match_pins), .irq(irq));
   pin_model #(.PINS(12)) u_pin_model (
      .aclk(aclk), .level_req(level_req), .capture_pins(capture_pins));

   always #4 aclk = ~aclk;

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      if (n_errors == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw_done, w_done, ta, tw;
      qb.push_back(r);
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= a;
      wdata <= d;
      bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(negedge aclk);
         ta = awready && !aw_done;
         tw = wready && !w_done;
         @(posedge aclk);
         if (ta) begin
            awvalid <= 1'b0;
            aw_done = 1'b1;
         end
         if (tw) begin
            wvalid <= 1'b0;
            w_done = 1'b1;
         end
      end
      do @(negedge aclk); while (!bvalid);
      @(posedge aclk);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      qr.push_back(e);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do @(negedge aclk); while (!arready);
      @(posedge aclk);
      arvalid <= 1'b0;
      do @(negedge aclk); while (!rvalid);
      @(posedge aclk);
      rready <= 1'b0;
   endtask

   // Responses are sampled mid-cycle, where ready and valid are settled.
   always @(negedge aclk) begin
      if (rvalid && rready)
         check({rdata, rresp}, qr.size() > 0 ? qr.pop_front() : 34'h0_dead_beef);
      if (bvalid && bready)
         check(bresp, qb.size() > 0 ? qb.pop_front() : 2'h1);
   end

   initial begin
      #(8 * 4000);
      n_errors++;
      wrap_up();
   end

   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata} = 48'h0000_0000_0000;
      wstrb = 4'hF;
      level_req = 12'h000;
      seed = 10;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFF_TC, {32'h0000_0000, RESP_OKAY});
      rd(8'h40, {32'h0000_0000, RESP_SLVERR});
      rnd = $random(seed);
      wr(OFF_MR0 + 8'h04, rnd, RESP_OKAY);
      rd(OFF_MR0 + 8'h04, {rnd, RESP_OKAY});
      wr(OFF_TC, 32'h0000_0009, RESP_OKAY);
      wr(OFF_TCR, 32'h0000_0002, RESP_OKAY);
      rd(OFF_TC, {32'h0000_0000, RESP_OKAY});
      wr(OFF_PR, 32'h0000_0003, RESP_OKAY);
      wr(OFF_MR0, 32'h0000_0005, RESP_OKAY);
      wr(OFF_MCR, 32'h0000_0005, RESP_OKAY);
      wr(OFF_EMR, 32'h0000_0030, RESP_OKAY);
      wr(OFF_MATSEL, 32'h0000_00FF, RESP_OKAY);
      wr(OFF_MASK, 32'h0000_00FF, RESP_OKAY);
      wr(OFF_TCR, 32'h0000_0001, RESP_OKAY);
      n = 0;
      while (irq !== 1'b1 && n < 200) begin
         @(negedge aclk);
         n++;
      end
      // Five counts of four clocks each, plus the write's own latency.
      check(n > 18 && n < 28, 1'b1);
      check(match_outputs[0], 1'b1);
      check(match_pins[1:0], 2'h3);
      rd(OFF_PC, {32'h0000_0000, RESP_OKAY});
      rd(OFF_IR, {32'h0000_0001, RESP_OKAY});
      repeat (3) @(negedge aclk);
      check(irq, 1'b0);
      rd(OFF_TC, {32'h0000_0005, RESP_OKAY});
      wr(OFF_CCR, 32'h0000_0028, RESP_OKAY);
      wr(OFF_CAPSEL, 32'h0000_0FFF, RESP_OKAY);
      level_req <= 12'h010;
      repeat (6) @(posedge aclk);
      rd(OFF_IR, {32'h0000_0000, RESP_OKAY});
      level_req <= 12'h018;
      repeat (6) @(posedge aclk);
      rd(OFF_IR, {32'h0000_0020, RESP_OKAY});
      rd(OFF_CR0 + 8'h04, {32'h0000_0005, RESP_OKAY});
      wr(OFF_CR0, 32'h0000_0001, RESP_SLVERR);
      wr(OFF_PR, 32'h0000_0000, RESP_OKAY);
      wr(OFF_MR0, 32'h0000_0006, RESP_OKAY);
      wr(OFF_MCR, 32'h0000_0003, RESP_OKAY);
      wr(OFF_CTCR, 32'h0000_0005, RESP_OKAY);
      wr(OFF_TCR, 32'h0000_0001, RESP_OKAY);
      // Two rises on the counting pin: the first reaches the match, the second resets.
      repeat (2) begin
         level_req <= 12'h010;
         repeat (6) @(posedge aclk);
         level_req <= 12'h018;
         repeat (6) @(posedge aclk);
      end
      rd(OFF_TC, {32'h0000_0000, RESP_OKAY});
      rd(OFF_CR0 + 8'h04, {32'h0000_0006, RESP_OKAY});
      rd(OFF_IR, {32'h0000_0021, RESP_OKAY});
      check(match_outputs[0], 1'b0);
      repeat (4) @(posedge aclk);
      wrap_up();
   end
endmodule
`default_nettype wire
